// >>> core/icache_control_diag_access.sv
// Summary of operation
// - Debugger instruction-sync request invalidates every cache entry.
// - Sixteen regions, each with two control bits, one being cacheable.
// - All cacheable bits zero means no fetch is ever cached.
// - Array field: 0 selects data array, 1 selects tag and status.
// - Way field picks way 0..3; index field picks the location.
// - Reading the trigger register reads the selected location into both data registers.
// - Writing one to go writes both data registers to the location.
// - Data access moves 32-bit chunk in data zero, check bits in data one.
// - Tag access moves tag, valid, replacement bits; tag check in data one.
// - Reserved and unused bits of the four registers read zero.
// - Read/write fields accept any value, read back only legal ones.
// - Data and tags in protected arrays; status bits in flip-flops.
// - Cache and control exist only when the build parameter enables them; the code always builds the arrays and the control and region registers.
// - Diagnostic writes can change instructions, tags, valid and replacement bits.
// - Diagnostic registers are accessible only in debug mode, else illegal.
// - Four ways, 64-byte lines, four 16-byte banks selected by index bits.
//
// The APB register port and the address map were left to the implementer.
module icache_control_diag_access
#(
  parameter bit cache_present_param = 1'b1 // Cache built in
)
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  input wire logic [3:0] fetch_region, // Region of current fetch
  output logic fetch_cacheable_ff, // Fetch may be cached
  output logic illegal_access_ff // Pulse: diag access outside debug mode
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  icache_diag_pkg::select_type select_ff;
  logic [31:0] data_zero_ff;
  logic [9:0] data_one_ff;
  logic debug_mode_ff;
  logic [31:0] region_ff;
  icache_diag_pkg::diag_state_type state_ff;
  logic [4:0] flush_cnt_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  logic answer;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic diag_reg;
  logic mapped;
  logic allowed;
  logic go_wr;
  logic trig_rd;
  logic sync_req;
  logic arr_wr;
  icache_diag_pkg::entry_type arr_rd;
  icache_diag_pkg::entry_type arr_wdata;
  logic [31:0] nxt_rdata;
  logic [31:0] one_merged;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_diag(input logic [11:0] a);
    return (a == icache_diag_pkg::select_off) || (a == icache_diag_pkg::data_zero_off) ||
           (a == icache_diag_pkg::data_one_off) || (a == icache_diag_pkg::trigger_off);
  endfunction

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign answer = psel && !pready_ff && (state_ff == icache_diag_pkg::st_idle);
  assign access = psel && penable && pready_ff;
  assign diag_reg = is_diag(paddr);
  assign mapped = diag_reg || (paddr == icache_diag_pkg::control_off) ||
                  (paddr == icache_diag_pkg::region_off) || (paddr == icache_diag_pkg::status_off);
  assign allowed = mapped && (!diag_reg || (debug_mode_ff && cache_present_param));
  assign wr_acc = access && pwrite && allowed;
  assign rd_acc = access && !pwrite && allowed;
  assign go_wr = wr_acc && (paddr == icache_diag_pkg::trigger_off) &&
                 pstrb[0] && pwdata[icache_diag_pkg::go_pos];
  assign trig_rd = rd_acc && (paddr == icache_diag_pkg::trigger_off);
  assign sync_req = wr_acc && (paddr == icache_diag_pkg::control_off) && pstrb[0] &&
                    pwdata[icache_diag_pkg::sync_pos] && cache_present_param;
  assign arr_wr = (state_ff == icache_diag_pkg::st_write);
  assign arr_wdata.word = data_zero_ff;
  assign arr_wdata.check = data_one_ff;
  assign one_merged = strb_merge({22'h000000, data_one_ff}, pwdata, pstrb);

  // No wait state on a transfer while idle; slower during trigger and flush
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= answer;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= icache_diag_pkg::st_idle;
      flush_cnt_ff <= 5'h00;
    end
    else
    begin
      unique case (state_ff)
        icache_diag_pkg::st_idle:
        begin
          if (sync_req)
          begin
            state_ff <= icache_diag_pkg::st_flush;
            flush_cnt_ff <= icache_diag_pkg::flush_cycles;
          end
          else if (go_wr)
          begin
            state_ff <= icache_diag_pkg::st_write;
          end
          else if (trig_rd)
          begin
            state_ff <= icache_diag_pkg::st_read;
          end
        end
        icache_diag_pkg::st_read, icache_diag_pkg::st_write:
        begin
          state_ff <= icache_diag_pkg::st_idle;
        end
        icache_diag_pkg::st_flush:
        begin
          flush_cnt_ff <= flush_cnt_ff - 5'h01;
          if (flush_cnt_ff == 5'h01)
          begin
            state_ff <= icache_diag_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Location select and data holding registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      select_ff <= '0;
    end
    else if (wr_acc && paddr == icache_diag_pkg::select_off)
    begin
      select_ff.array_sel <= pwdata[icache_diag_pkg::array_pos];
      select_ff.way <= pwdata[icache_diag_pkg::way_lo +: 2];
      select_ff.index <= pwdata[icache_diag_pkg::index_lo +: icache_diag_pkg::index_w];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_zero_ff <= icache_diag_pkg::reg_reset;
      data_one_ff <= 10'h000;
    end
    else if (state_ff == icache_diag_pkg::st_read)
    begin
      data_zero_ff <= arr_rd.word;
      data_one_ff <= arr_rd.check;
    end
    else
    begin
      if (wr_acc && paddr == icache_diag_pkg::data_zero_off)
      begin
        data_zero_ff <= strb_merge(data_zero_ff, pwdata, pstrb);
      end
      if (wr_acc && paddr == icache_diag_pkg::data_one_off)
      begin
        data_one_ff <= one_merged[9:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Control, regions and debug mode
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      debug_mode_ff <= 1'b0;
      region_ff <= icache_diag_pkg::region_reset;
    end
    else
    begin
      if (wr_acc && paddr == icache_diag_pkg::control_off && pstrb[0])
      begin
        debug_mode_ff <= pwdata[icache_diag_pkg::debug_pos];
      end
      if (wr_acc && paddr == icache_diag_pkg::region_off)
      begin
        region_ff <= strb_merge(region_ff, pwdata, pstrb);
      end
    end
  end

  // Cacheable bit is the even bit of each region's pair
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fetch_cacheable_ff <= 1'b0;
    end
    else
    begin
      fetch_cacheable_ff <= cache_present_param && region_ff[{fetch_region, 1'b0}] &&
                            (state_ff != icache_diag_pkg::st_flush);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      illegal_access_ff <= 1'b0;
    end
    else
    begin
      illegal_access_ff <= access && diag_reg && !allowed;
    end
  end

  // ------------------------------------------------------------------
  // Read mux and response
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      icache_diag_pkg::select_off:
        nxt_rdata = {7'h00, select_ff.array_sel, 2'h0, select_ff.way, 4'h0,
                     select_ff.index, 2'h0};
      icache_diag_pkg::data_zero_off:
        nxt_rdata = select_ff.array_sel ? {data_zero_ff[31:12], 5'h00, data_zero_ff[6:4], 3'h0,
                    data_zero_ff[0]} : data_zero_ff;
      icache_diag_pkg::data_one_off:
        nxt_rdata = select_ff.array_sel ? {27'h0000000, data_one_ff[4:0]}
                                        : {22'h000000, data_one_ff};
      icache_diag_pkg::control_off:
        nxt_rdata = {30'h00000000, debug_mode_ff, 1'b0};
      icache_diag_pkg::region_off:
        nxt_rdata = region_ff;
      icache_diag_pkg::status_off:
        nxt_rdata = {29'h00000000, cache_present_param, state_ff};
      default:
        nxt_rdata = 32'h0000_0000; // Trigger go reads zero
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= (answer && !pwrite && allowed) ? nxt_rdata : 32'h0000_0000;
      pslverr_ff <= answer && !allowed;
    end
  end

  assign pready = pready_ff;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // ------------------------------------------------------------------
  // Arrays
  // ------------------------------------------------------------------
  icache_arrays u_arrays
  (
    .pclk(pclk),
    .presetn(presetn),
    .sel(select_ff),
    .wr_en(arr_wr && cache_present_param),
    .wr_data(arr_wdata),
    .flush(state_ff == icache_diag_pkg::st_flush),
    .rd_data(arr_rd)
  );

endmodule // icache_control_diag_access

// >>> core/icache_diag_pkg.sv
package icache_diag_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] select_off = 12'h000;
  localparam logic [11:0] data_zero_off = 12'h004;
  localparam logic [11:0] data_one_off = 12'h008;
  localparam logic [11:0] trigger_off = 12'h00c;
  localparam logic [11:0] control_off = 12'h010;
  localparam logic [11:0] region_off = 12'h014;
  localparam logic [11:0] status_off = 12'h018;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int array_pos = 24;
  localparam int way_lo = 20;
  localparam int index_lo = 2;
  localparam int index_w = 14;
  localparam int tag_lo = 12;
  localparam int tag_w = 20;
  localparam int valid_pos = 0;
  localparam int lru_lo = 4;
  localparam int check_w = 10;
  localparam int tag_check_w = 5;
  localparam int go_pos = 0;
  localparam int sync_pos = 0;
  localparam int debug_pos = 1;

  // ------------------------------------------------------------------
  // Geometry and reset values
  // ------------------------------------------------------------------
  localparam int ways = 4;
  localparam int sets = 16;
  localparam int chunk_sel_w = 4;
  localparam int set_sel_w = 4;
  localparam int regions = 16;
  localparam logic [31:0] reg_reset = 32'h0000_0000;
  localparam logic [31:0] region_reset = 32'h0000_0000;
  localparam logic [4:0] flush_cycles = 5'h10;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_read = 2'b01,
    st_write = 2'b11,
    st_flush = 2'b10
  } diag_state_type;

  typedef struct packed {
    logic array_sel;
    logic [1:0] way;
    logic [13:0] index;
  } select_type;

  typedef struct packed {
    logic [31:0] word;
    logic [9:0] check;
  } entry_type;

endpackage

// >>> core/icache_arrays.sv
module icache_arrays
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire icache_diag_pkg::select_type sel, // Location
  input wire logic wr_en, // Write strobe
  input wire icache_diag_pkg::entry_type wr_data, // Write word and check bits
  input wire logic flush, // Invalidate all lines
  output icache_diag_pkg::entry_type rd_data // Combinational read
);

  localparam int data_depth = icache_diag_pkg::ways * icache_diag_pkg::sets * 16;
  localparam int tag_depth = icache_diag_pkg::ways * icache_diag_pkg::sets;

  // SRAM-style stores carry word plus check bits, no reset
  logic [41:0] data_mem [data_depth];
  logic [24:0] tag_mem [tag_depth];
  logic [tag_depth-1:0] valid_ff;
  logic [2:0] lru_ff [icache_diag_pkg::sets];

  logic [9:0] data_addr;
  logic [5:0] tag_addr;
  logic [3:0] set_idx;

  assign set_idx = sel.index[13:10];
  assign data_addr = {sel.way, set_idx, sel.index[3:0]};
  assign tag_addr = {sel.way, set_idx};

  always_ff @(posedge pclk)
  begin
    if (wr_en && !sel.array_sel)
    begin
      data_mem[data_addr] <= {wr_data.word, wr_data.check};
    end
    if (wr_en && sel.array_sel)
    begin
      tag_mem[tag_addr] <= {wr_data.word[31:12], wr_data.check[4:0]};
    end
  end

  // Status bits in flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_ff <= '0;
    end
    else if (flush)
    begin
      valid_ff <= '0;
    end
    else if (wr_en && sel.array_sel)
    begin
      valid_ff[tag_addr] <= wr_data.word[icache_diag_pkg::valid_pos];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < icache_diag_pkg::sets; i++)
      begin
        lru_ff[i] <= 3'h0;
      end
    end
    else if (wr_en && sel.array_sel)
    begin
      lru_ff[set_idx] <= wr_data.word[6:4];
    end
  end

  always_comb
  begin
    rd_data = '0;
    if (!sel.array_sel)
    begin
      rd_data.word = data_mem[data_addr][41:10];
      rd_data.check = data_mem[data_addr][9:0];
    end
    else
    begin
      rd_data.word = {tag_mem[tag_addr][24:5], 5'h00, lru_ff[set_idx], 3'h0, valid_ff[tag_addr]};
      rd_data.check = {5'h00, tag_mem[tag_addr][4:0]};
    end
  end

endmodule // icache_arrays

// >>> test/icache_control_diag_access_assertions.sv
module icache_diag_checker
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic illegal_access_ff // Refusal pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ans_max = 24;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Transfer steps
  // ------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    ##[1:ans_max] (psel && penable && pready);
  endsequence
  sequence s_refused;
    pready && pslverr && paddr <= 12'h00c;
  endsequence
  property p_answer;
    s_setup |-> s_answer;
  endproperty
  a_answer: assert property (p_answer)
    else $error("Transfer not answered in time");
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("Ready held too long");
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  a_in_access: assert property (p_in_access)
    else $error("Ready outside access phase");
  property p_idle_data;
    !(pready && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("Read data not zero when idle");
  property p_refuse_pulse;
    s_refused |=> illegal_access_ff;
  endproperty
  a_refuse_pulse: assert property (p_refuse_pulse)
    else $error("No illegal pulse after refusal");
  property p_pulse_cause;
    illegal_access_ff |-> $past(pready && pslverr && paddr <= 12'h00c);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("Illegal pulse without refusal");
  property p_unmapped;
    pready && paddr > 12'h018 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access not refused");
  property p_go_zero;
    pready && !pwrite && paddr == 12'h00c |-> prdata == 32'h0;
  endproperty
  a_go_zero: assert property (p_go_zero)
    else $error("Trigger read not zero");
  property p_select_legal;
    pready && !pwrite && paddr == 12'h000 |-> (prdata & 32'hfecf_0003) == 32'h0;
  endproperty
  a_select_legal: assert property (p_select_legal)
    else $error("Select reserved bits set");
endmodule // icache_diag_checker

bind icache_control_diag_access icache_diag_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .illegal_access_ff(illegal_access_ff));

// >>> test/icache_control_diag_access_tb_top.sv
module icache_control_diag_access_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] fetch_region = 4'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic fetch_cacheable_ff;
  logic illegal_access_ff;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;

  always #25 pclk = ~pclk;

  icache_control_diag_access dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch_region(fetch_region),
    .fetch_cacheable_ff(fetch_cacheable_ff), .illegal_access_ff(illegal_access_ff));

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("ready", {31'h0, pready}, 32'h1);
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
    check("write err", {31'h0, err}, 32'h0);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rd, exp);
  endtask

  function automatic logic [31:0] sel_of(input int j);
    return (j < 16) ? (32'(j) << 2) : ((32'(j - 16) << 20) | 32'h0000_1000);
  endfunction

  task automatic load(input logic [31:0] sel);
    wr(icache_diag_pkg::select_off, sel);
    wr(icache_diag_pkg::data_zero_off, 32'h0);
    wr(icache_diag_pkg::data_one_off, 32'h0);
    rd_chk("trigger", icache_diag_pkg::trigger_off, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, icache_diag_pkg::select_off, 32'h0);
    check("refused", {31'h0, err}, 32'h1);
    rd_chk("region reset", icache_diag_pkg::region_off, icache_diag_pkg::region_reset);
    rd_chk("status", icache_diag_pkg::status_off, 32'h4);
    wr(icache_diag_pkg::control_off, 32'h2);
    wr(icache_diag_pkg::select_off, 32'hffff_ffff);
    rd_chk("select", icache_diag_pkg::select_off, 32'h0130_fffc);
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    // Whole line in way 0, then one chunk in every way
    for (int j = 0; j < 20; j++)
    begin
      wr(icache_diag_pkg::select_off, sel_of(j));
      wr(icache_diag_pkg::data_zero_off, 32'ha5c3_0000 ^ (32'(j) * 32'h0101_0101));
      wr(icache_diag_pkg::data_one_off, 32'(j * 37 + 5));
      wr(icache_diag_pkg::trigger_off, 32'h1);
    end
    for (int j = 0; j < 20; j++)
    begin
      load(sel_of(j));
      rd_chk("instr", 12'h004, 32'ha5c3_0000 ^ (32'(j) * 32'h0101_0101));
      rd_chk("check", 12'h008, 32'(j * 37 + 5) & 32'h3ff);
    end
    // Tag and status of way 2, set 3
    wr(icache_diag_pkg::select_off, 32'h0120_3000);
    wr(icache_diag_pkg::data_zero_off, 32'hffff_ffff);
    wr(icache_diag_pkg::data_one_off, 32'hffff_ffff);
    wr(icache_diag_pkg::trigger_off, 32'h1);
    load(32'h0120_3000);
    rd_chk("tag", icache_diag_pkg::data_zero_off, 32'hffff_f071);
    rd_chk("tag check", icache_diag_pkg::data_one_off, 32'h0000_001f);
    wr(icache_diag_pkg::control_off, 32'h3);
    rd_chk("sync clear", icache_diag_pkg::control_off, 32'h2);
    load(32'h0120_3000);
    rd_chk("valid", icache_diag_pkg::data_zero_off, 32'hffff_f070);
    // Region cacheable bits
    for (int k = 0; k < 2; k++)
    begin
      wr(icache_diag_pkg::region_off, k ? 32'haaaa_aaaa : 32'h5555_5555);
      for (int r = 0; r < 16; r++)
      begin
        fetch_region <= 4'(r);
        repeat (2) @(posedge pclk);
        check("cacheable", {31'h0, fetch_cacheable_ff}, k ? 32'h0 : 32'h1);
      end
    end
    rd_chk("region", icache_diag_pkg::region_off, 32'haaaa_aaaa);
    wr(icache_diag_pkg::control_off, 32'h0);
    apb(1'b1, icache_diag_pkg::data_zero_off, 32'h1);
    check("refused write", {31'h0, err}, 32'h1);
    test_done();
  end

  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end
endmodule // icache_control_diag_access_tb_top
